/* File: hdl/uhtwc_pkg.sv */
// shared constants for the usb handshake, timer and wakeup control ends
package uhtwc_pkg;
    // ------------------------------------------------------------
    // widths and device register map
    // ------------------------------------------------------------
    localparam int AW = 16;
    localparam int DW = 8;
    localparam logic [15:0] TSR_ADDR = 16'hff6c; // timer_start_reservation
    localparam logic [15:0] BLF_ADDR = 16'hff6d; // bus_level_force_control
    localparam logic [15:0] HSR_ADDR = 16'hff6e; // handshake reservations
    localparam logic [15:0] RXM_ADDR = 16'hff6f; // rx_mode_reg
    localparam logic [15:0] PRS_ADDR = 16'hff70; // packet_rx_status_reg
    localparam logic [15:0] TMC_ADDR = 16'hff71; // timer mode
    localparam logic [15:0] TMV_ADDR = 16'hff72; // timer count
    localparam logic [7:0] TSR_RST = 8'h01;
    localparam logic [7:0] BLF_RST = 8'h08;
    localparam logic [7:0] BLF_RESUME_K = 8'h07;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TSR_SETOUT = 0; // start_after_setup_out_rx
    localparam int TSR_START_AFTER_DATA_TX = 1; // start_after_data_tx
    localparam int BLF_WAKE = 0;
    localparam int BLF_FEN = 1; // force_level_enable
    localparam int BLF_DP = 2; // dplus_force_level
    localparam int BLF_DM = 3; // dminus_force_level
    localparam int HSR_EP1B0 = 0; // ep1_buf0_send_resv
    localparam int HSR_EP1B1 = 1; // ep1_buf1_send_resv
    localparam int HSR_EP1ST = 2; // ep1_stall_resv
    localparam int HSR_EP1NAK = 3; // ep1_nak_resv
    localparam int HSR_DSTALL = 4; // data_stall_resv
    localparam int HSR_DNAK = 5; // data_nak_resv
    localparam int HSR_DACK = 6; // data_ack_resv
    localparam int RXM_WMASK = 0; // rx_write_mask
    localparam int PRS_RUNAWAY = 7; // clock_runaway_err
    localparam int TMC_LOWSPD = 0;
    localparam logic [6:0] HS_TOP = 7'h3f;
    localparam logic [6:0] LS_TOP = 7'h7f;
    // ------------------------------------------------------------
    // controller command port map and timing
    // ------------------------------------------------------------
    localparam logic [7:0] H_CTRL = 8'h00; // w: resume start/end, r: status
    localparam logic [7:0] H_RESV = 8'h01;
    localparam logic [7:0] H_TSR = 8'h02;
    localparam logic [7:0] H_MODE = 8'h03;
    localparam logic [7:0] H_PRS = 8'h04;
    localparam logic [7:0] H_PEEK = 8'h05;
    localparam int CTL_START = 0;
    localparam int CTL_END = 1;
    localparam int IDLE_TIME_MS = 5;
    localparam int CLK_HZ = 40000000;
    localparam int IDLE_CYCLES = IDLE_TIME_MS * (CLK_HZ / 1000);
endpackage

/* File: hdl/uhtwc_if.sv */
// register link between the controller end and the device end
`timescale 1ns/1ps
interface uhtwc_if;
    logic [uhtwc_pkg::AW-1:0] addr;
    logic [uhtwc_pkg::DW-1:0] wdata;
    logic wr;
    logic rd;
    logic [uhtwc_pkg::DW-1:0] rdata;
    logic bus_idle;
    modport dev (input addr, wdata, wr, rd, output rdata, bus_idle);
    modport host (output addr, wdata, wr, rd, input rdata, bus_idle);
endinterface

/* File: hdl/uhtwc_dev.sv */
// device end: reservation registers, usb timer, handshake answers, level forcing
`timescale 1ns/1ps
module uhtwc_dev (
    input wire logic clk_in, // 40 mhz clock
    input wire logic reset_in, // synchronous reset, active high
    uhtwc_if.dev bus_io, // register link
    input wire logic token_eop_in, // token eop pulse
    input wire logic in_token_in, // token is in
    input wire logic out_token_seen_in, // token is out
    input wire logic setup_token_seen_in, // token is setup
    input wire logic address_match_in, // address matched
    input wire logic ep0_addressed_in, // endpoint 0
    input wire logic ep1_addressed_in, // endpoint 1
    input wire logic token_byte_len_err_in, // token length error
    input wire logic token_bit_err_in, // token bit stuff error
    input wire logic crc5_err_in, // token crc error
    input wire logic rx_data_eop_in, // received data eop pulse
    input wire logic tx_data_eop_in, // transmitted data eop pulse
    input wire logic data_pid_match_in, // data pid matched
    input wire logic data_byte_len_err_in, // data length error
    input wire logic data_bit_err_in, // data bit stuff error
    input wire logic crc16_err_in, // data crc error
    input wire logic sync_det_in, // sync seen
    input wire logic usb_reset_det_in, // usb reset seen
    input wire logic resume_det_in, // resume seen
    input wire logic usb_tick_in, // usb clock enable tick
    input wire logic bus_idle_in, // line idle, asynchronous
    input wire logic txbuf_dp_in, // transmit buffer d+
    input wire logic txbuf_dm_in, // transmit buffer d-
    input wire logic txbuf_oe_in, // transmit buffer drives
    output logic dplus_tx_pin_out, // d+ to driver
    output logic dminus_tx_pin_out, // d- to driver
    output logic tx_oe_out, // driver enable
    output logic ack_send_out, // send ack pulse
    output logic ep1_nak_send_out, // send nak pulse
    output logic timer_overflow_irq_out, // overflow pulse
    output logic usb_clk_stop_out // usb clock forced off
);
    typedef struct packed {
        logic [1:0] tsr;
        logic [3:0] blf;
        logic [6:0] hsr;
        logic wmask;
        logic runaway;
        logic low_speed;
        logic run;
        logic [6:0] cnt;
        logic [7:0] rdata;
        logic dp;
        logic dm;
        logic oe;
        logic ack;
        logic nak1;
        logic irq;
        logic idle_m;
        logic idle_s;
    } uhtwc_dev_s;

    uhtwc_dev_s q;
    uhtwc_dev_s d;
    logic tok_ok;
    logic data_ok;
    logic setup_ok;
    logic so_start;
    logic tx_start;
    logic ls_start;

    // ------------------------------------------------------------
    // packet qualifiers
    // ------------------------------------------------------------
    // shared error-free checks keep the start and answer terms alike
    assign tok_ok = token_eop_in & address_match_in & ~token_byte_len_err_in
        & ~token_bit_err_in & ~crc5_err_in;
    assign data_ok = data_pid_match_in & ~data_byte_len_err_in & ~data_bit_err_in
        & ~crc16_err_in;
    assign setup_ok = tok_ok & setup_token_seen_in & ep0_addressed_in;
    assign so_start = q.tsr[uhtwc_pkg::TSR_SETOUT] & tok_ok & ep0_addressed_in
        & (setup_token_seen_in | out_token_seen_in);
    assign tx_start = q.tsr[uhtwc_pkg::TSR_START_AFTER_DATA_TX] & tx_data_eop_in & data_ok;
    assign ls_start = sync_det_in | usb_reset_det_in | resume_det_in;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.nak1 = 1'b0;
        d.irq = 1'b0;
        d.rdata = 8'h00;
        // idle level comes from the line, so it is synchronised first
        d.idle_m = bus_idle_in;
        d.idle_s = q.idle_m;
        // software writes; hardware events below override them
        if (bus_io.wr) begin
            if (bus_io.addr == uhtwc_pkg::TSR_ADDR) begin
                d.tsr = bus_io.wdata[1:0];
            end else if (bus_io.addr == uhtwc_pkg::BLF_ADDR) begin
                d.blf = bus_io.wdata[3:0];
            end else if (bus_io.addr == uhtwc_pkg::HSR_ADDR) begin
                d.hsr = bus_io.wdata[6:0];
            end else if (bus_io.addr == uhtwc_pkg::RXM_ADDR) begin
                d.wmask = bus_io.wdata[uhtwc_pkg::RXM_WMASK];
            end else if (bus_io.addr == uhtwc_pkg::PRS_ADDR) begin
                // writing zero clears the runaway flag and restarts the clock
                d.runaway = q.runaway & bus_io.wdata[uhtwc_pkg::PRS_RUNAWAY];
            end else if (bus_io.addr == uhtwc_pkg::TMC_ADDR) begin
                d.low_speed = bus_io.wdata[uhtwc_pkg::TMC_LOWSPD];
                d.run = 1'b0; // a mode change abandons the current count
                d.cnt = 7'h00;
            end
        end
        // register reads, unused bits read as zero
        if (bus_io.rd) begin
            if (bus_io.addr == uhtwc_pkg::TSR_ADDR) begin
                d.rdata = {6'h00, q.tsr};
            end else if (bus_io.addr == uhtwc_pkg::BLF_ADDR) begin
                d.rdata = {4'h0, q.blf};
            end else if (bus_io.addr == uhtwc_pkg::HSR_ADDR) begin
                d.rdata = {1'b0, q.hsr};
            end else if (bus_io.addr == uhtwc_pkg::RXM_ADDR) begin
                d.rdata = {7'h00, q.wmask};
            end else if (bus_io.addr == uhtwc_pkg::PRS_ADDR) begin
                d.rdata = {q.runaway, 7'h00};
            end else if (bus_io.addr == uhtwc_pkg::TMC_ADDR) begin
                d.rdata = {7'h00, q.low_speed};
            end else if (bus_io.addr == uhtwc_pkg::TMV_ADDR) begin
                d.rdata = {q.run, q.cnt};
            end
        end
        // a valid setup wins over a software write in the same cycle
        if (setup_ok) begin
            d.tsr = uhtwc_pkg::TSR_RST[1:0];
        end
        // handshake answers
        d.ack = q.hsr[uhtwc_pkg::HSR_DACK] & rx_data_eop_in & data_ok;
        d.nak1 = q.hsr[uhtwc_pkg::HSR_EP1NAK] & tok_ok & in_token_in
            & ep1_addressed_in;
        // usb timer
        if (!q.low_speed) begin
            // fast mode counts every clock and stops at the six-bit top
            if (q.run) begin
                if (q.cnt == uhtwc_pkg::HS_TOP) begin
                    d.irq = 1'b1;
                    d.run = 1'b0;
                    d.cnt = 7'h00;
                end else begin
                    d.cnt = q.cnt + 7'h01;
                end
            end
            if (so_start | tx_start) begin
                d.run = 1'b1;
                d.cnt = 7'h00;
            end
        end else begin
            // slow mode counts usb clock ticks; no ticks arrive once stopped
            if (q.run && usb_tick_in && !q.runaway) begin
                if (q.cnt == uhtwc_pkg::LS_TOP) begin
                    d.irq = 1'b1;
                    d.runaway = 1'b1;
                    d.run = 1'b0;
                    d.cnt = 7'h00;
                end else begin
                    d.cnt = q.cnt + 7'h01;
                end
            end
            if (ls_start && !d.runaway) begin
                d.run = 1'b1;
                d.cnt = 7'h00;
            end
        end
        // driver source and wakeup gate
        if (q.blf[uhtwc_pkg::BLF_FEN]) begin
            d.dp = q.blf[uhtwc_pkg::BLF_DP];
            d.dm = q.blf[uhtwc_pkg::BLF_DM];
        end else begin
            d.dp = txbuf_dp_in;
            d.dm = txbuf_dm_in;
        end
        d.oe = q.blf[uhtwc_pkg::BLF_WAKE] | txbuf_oe_in;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            q <= '0;
            q.tsr <= uhtwc_pkg::TSR_RST[1:0];
            q.blf <= uhtwc_pkg::BLF_RST[3:0];
            q.dm <= uhtwc_pkg::BLF_RST[uhtwc_pkg::BLF_DM];
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign bus_io.rdata = q.rdata;
    assign bus_io.bus_idle = q.idle_s;
    assign dplus_tx_pin_out = q.dp;
    assign dminus_tx_pin_out = q.dm;
    assign tx_oe_out = q.oe;
    assign ack_send_out = q.ack;
    assign ep1_nak_send_out = q.nak1;
    assign timer_overflow_irq_out = q.irq;
    assign usb_clk_stop_out = q.runaway;
endmodule

/* File: hdl/uhtwc_host.sv */
// controller end: checked reservation writes, resume sequencing, register peek
`timescale 1ns/1ps
module uhtwc_host #(
    parameter int IDLE_CYCLES = uhtwc_pkg::IDLE_CYCLES // idle wait before resume
) (
    input wire logic clk_in, // 40 mhz clock
    input wire logic reset_in, // synchronous reset, active high
    uhtwc_if.host bus_io, // register link
    input wire logic [7:0] cmd_addr_in, // command offset
    input wire logic [7:0] cmd_wdata_in, // command write data
    input wire logic cmd_wr_in, // write strobe
    input wire logic cmd_rd_in, // read strobe
    output logic [7:0] cmd_rdata_out // read data, cycle after strobe
);
    localparam int IW = $clog2(IDLE_CYCLES + 2);
    localparam logic [IW-1:0] IDLE_DONE = IW'(IDLE_CYCLES + 1);

    typedef enum logic [2:0] {K_NONE, K_START, K_END, K_RESV, K_FWD, K_PEEK} uhtwc_kind_e;
    typedef struct packed {
        uhtwc_kind_e kind;
        logic [2:0] step;
        logic [7:0] val;
        logic [15:0] fa;
        logic [7:0] blf;
        logic [IW-1:0] idle;
        logic k_on;
        logic refused;
        logic peek_wait;
        logic [7:0] peek;
        logic [7:0] rdata;
        logic [15:0] ba;
        logic [7:0] bwd;
        logic bwr;
        logic brd;
    } uhtwc_host_s;

    uhtwc_host_s q;
    uhtwc_host_s d;
    logic rsv_ok;

    // ------------------------------------------------------------
    // reservation checks
    // ------------------------------------------------------------
    // at most one endpoint 1 reservation, and data nak excludes data stall and data ack
    assign rsv_ok = ($countones(cmd_wdata_in[uhtwc_pkg::HSR_EP1NAK:0]) <= 1)
        && !(cmd_wdata_in[uhtwc_pkg::HSR_DSTALL] && cmd_wdata_in[uhtwc_pkg::HSR_DNAK])
        && !(cmd_wdata_in[uhtwc_pkg::HSR_DACK] && cmd_wdata_in[uhtwc_pkg::HSR_DNAK]);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.bwr = 1'b0;
        d.brd = 1'b0;
        d.rdata = 8'h00;
        d.peek_wait = q.brd;
        if (q.peek_wait) begin
            d.peek = bus_io.rdata;
        end
        // idle time, saturating; any activity restarts it
        if (!bus_io.bus_idle) begin
            d.idle = '0;
        end else if (q.idle != IDLE_DONE) begin
            d.idle = q.idle + IW'(1);
        end
        // command reads; a read of status clears the refused flag
        if (cmd_rd_in) begin
            if (cmd_addr_in == uhtwc_pkg::H_CTRL) begin
                d.rdata = {4'h0, q.k_on, (q.idle == IDLE_DONE), q.refused,
                    (q.kind != K_NONE)};
                d.refused = 1'b0;
            end else if (cmd_addr_in == uhtwc_pkg::H_PEEK) begin
                d.rdata = q.peek;
            end
        end
        // command writes are taken only while no sequence runs
        if (cmd_wr_in) begin
            if (q.kind != K_NONE) begin
                d.refused = 1'b1;
            end else if (cmd_addr_in == uhtwc_pkg::H_CTRL) begin
                if (cmd_wdata_in[uhtwc_pkg::CTL_START] && !q.k_on
                    && q.idle == IDLE_DONE) begin
                    d.kind = K_START;
                end else if (cmd_wdata_in[uhtwc_pkg::CTL_END] && q.k_on) begin
                    d.kind = K_END;
                end else begin
                    d.refused = 1'b1;
                end
            end else if (cmd_addr_in == uhtwc_pkg::H_RESV) begin
                if (rsv_ok) begin
                    d.kind = K_RESV;
                    d.val = cmd_wdata_in;
                end else begin
                    d.refused = 1'b1;
                end
            end else if (cmd_addr_in == uhtwc_pkg::H_TSR) begin
                d.kind = K_FWD;
                d.fa = uhtwc_pkg::TSR_ADDR;
                d.val = cmd_wdata_in;
            end else if (cmd_addr_in == uhtwc_pkg::H_MODE) begin
                d.kind = K_FWD;
                d.fa = uhtwc_pkg::TMC_ADDR;
                d.val = cmd_wdata_in;
            end else if (cmd_addr_in == uhtwc_pkg::H_PRS) begin
                d.kind = K_FWD;
                d.fa = uhtwc_pkg::PRS_ADDR;
                d.val = cmd_wdata_in;
            end else if (cmd_addr_in == uhtwc_pkg::H_PEEK) begin
                d.kind = K_PEEK;
                d.fa = uhtwc_pkg::TSR_ADDR + {13'h0000, cmd_wdata_in[2:0]};
            end else begin
                d.refused = 1'b1;
            end
            d.step = 3'h0;
        end
        // one device access per cycle while a sequence runs
        case (q.kind)
            K_START: begin
                d.bwr = 1'b1;
                d.ba = uhtwc_pkg::BLF_ADDR;
                d.step = q.step + 3'h1;
                case (q.step)
                    3'h0: d.blf = q.blf | (8'h01 << uhtwc_pkg::BLF_DM);
                    3'h1: d.blf = q.blf & ~(8'h01 << uhtwc_pkg::BLF_DP);
                    3'h2: d.blf = q.blf | (8'h01 << uhtwc_pkg::BLF_FEN);
                    3'h3: d.blf = q.blf | (8'h01 << uhtwc_pkg::BLF_WAKE); // j state
                    default: begin
                        d.blf = uhtwc_pkg::BLF_RESUME_K; // k state, whole register
                        d.kind = K_NONE;
                        d.k_on = 1'b1;
                    end
                endcase
                d.bwd = d.blf;
            end
            K_END: begin
                d.bwr = 1'b1;
                d.ba = uhtwc_pkg::BLF_ADDR;
                d.step = q.step + 3'h1;
                case (q.step)
                    3'h0: d.blf = q.blf & ~(8'h01 << uhtwc_pkg::BLF_WAKE);
                    3'h1: d.blf = q.blf & ~(8'h01 << uhtwc_pkg::BLF_FEN);
                    3'h2: d.blf = q.blf & ~(8'h01 << uhtwc_pkg::BLF_DP);
                    default: begin
                        d.blf = q.blf | (8'h01 << uhtwc_pkg::BLF_DM);
                        d.kind = K_NONE;
                        d.k_on = 1'b0;
                    end
                endcase
                d.bwd = d.blf;
            end
            K_RESV: begin
                // the write mask goes in first so no data is lost while nak stands
                d.bwr = 1'b1;
                d.step = q.step + 3'h1;
                if (q.step == 3'h0) begin
                    d.ba = uhtwc_pkg::RXM_ADDR;
                    d.bwd = {7'h00, q.val[uhtwc_pkg::HSR_DNAK]};
                end else begin
                    d.ba = uhtwc_pkg::HSR_ADDR;
                    d.bwd = q.val;
                    d.kind = K_NONE;
                end
            end
            K_FWD: begin
                d.bwr = 1'b1;
                d.ba = q.fa;
                d.bwd = q.val;
                d.kind = K_NONE;
            end
            K_PEEK: begin
                d.brd = 1'b1;
                d.ba = q.fa;
                d.kind = K_NONE;
            end
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            q <= '0;
            q.kind <= K_NONE;
            q.blf <= uhtwc_pkg::BLF_RST;
        end else begin
            q <= d;
        end
    end

    assign bus_io.addr = q.ba;
    assign bus_io.wdata = q.bwd;
    assign bus_io.wr = q.bwr;
    assign bus_io.rd = q.brd;
    assign cmd_rdata_out = q.rdata;
endmodule

/* File: tb/uhtwc_monitor.sv */
// link assertions between the controller end and the device end
`timescale 1ns/1ps
module uhtwc_monitor #(
    parameter int IDLE_CYCLES = 20 // idle wait before resume
) (
    input wire logic clk_in, // clock
    input wire logic reset_in, // reset, active high
    input wire logic [uhtwc_pkg::AW-1:0] addr, // link address
    input wire logic [uhtwc_pkg::DW-1:0] wdata, // link write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [uhtwc_pkg::DW-1:0] rdata, // read data
    input wire logic bus_idle // synced idle level
);
    // ----------------------------------------
    // idle run length and write decodes
    // ----------------------------------------
    logic [31:0] idle_q;
    // no saturation: idle runs stay short in simulation
    always_ff @(posedge clk_in) idle_q <= (reset_in || !bus_idle) ? 32'h0 : idle_q + 32'h1;
    wire hw = wr && addr == uhtwc_pkg::HSR_ADDR;
    wire bw = wr && addr == uhtwc_pkg::BLF_ADDR;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_tsr_upper_zero: assert property (
        rd && addr == uhtwc_pkg::TSR_ADDR |=> rdata[7:2] == 6'h00) else $error("tsr upper bits");
    a_ep1_one_resv: assert property (
        hw |-> $onehot0(wdata[3:0])) else $error("two ep1 reservations");
    a_stall_nak_excl: assert property (
        hw |-> !(wdata[4] && wdata[5])) else $error("stall with nak");
    a_ack_nak_excl: assert property (
        hw |-> !(wdata[6] && wdata[5])) else $error("ack with nak");
    a_mask_first: assert property (
        hw && wdata[5] |-> $past(wr) && $past(wdata[0]) && $past(addr) == uhtwc_pkg::RXM_ADDR)
        else $error("nak without write mask");
    a_idle_wake: assert property (
        bw && wdata == 8'h0b |-> idle_q >= 32'(IDLE_CYCLES)) else $error("wakeup too early");
    a_k_after_j: assert property (
        bw && wdata == 8'h07 |-> $past(bw) && $past(wdata) == 8'h0b) else $error("k without j");
    a_eop_order: assert property (
        bw && wdata == 8'h06 |=> bw && wdata == 8'h04 ##1 bw && wdata == 8'h00 ##1 bw
        && wdata == 8'h08) else $error("resume end order");
endmodule

/* File: tb/uhtwc_bench.sv */
// self-checking bench: both ends joined over the link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module uhtwc_bench;
    logic clk_in = 0, reset_in = 1, tick = 0, idle = 0, tok, dok, cw = 0, cr = 0;
    logic dp, dm, oe, ack, nak, irq, stp;
    logic [18:0] ev = 0, v;
    logic [2:0] txb = 0;
    logic [1:0] an;
    logic [7:0] ca = 0, cd = 0, rv, st, tsr, rsv, crd;
    logic [31:0] r, s;
    int n_mismatch = 0, total_checks = 0, cyc = 0, n, k, e, seed = 32'h954d;
    int kb[3] = '{11, 0, 10};
    uhtwc_if link();
    uhtwc_dev uhtwc_dev_inst (.clk_in, .reset_in, .bus_io(link.dev), .token_eop_in(ev[0]),
        .in_token_in(ev[1]), .out_token_seen_in(ev[2]), .setup_token_seen_in(ev[3]),
        .address_match_in(ev[4]), .ep0_addressed_in(ev[5]), .ep1_addressed_in(ev[6]),
        .token_byte_len_err_in(ev[7]), .token_bit_err_in(ev[8]), .crc5_err_in(ev[9]),
        .rx_data_eop_in(ev[10]), .tx_data_eop_in(ev[11]), .data_pid_match_in(ev[12]),
        .data_byte_len_err_in(ev[13]), .data_bit_err_in(ev[14]), .crc16_err_in(ev[15]),
        .sync_det_in(ev[16]), .usb_reset_det_in(ev[17]), .resume_det_in(ev[18]),
        .usb_tick_in(tick), .bus_idle_in(idle), .txbuf_dp_in(txb[0]), .txbuf_dm_in(txb[1]),
        .txbuf_oe_in(txb[2]), .dplus_tx_pin_out(dp), .dminus_tx_pin_out(dm), .tx_oe_out(oe),
        .ack_send_out(ack), .ep1_nak_send_out(nak), .timer_overflow_irq_out(irq),
        .usb_clk_stop_out(stp));
    uhtwc_host #(.IDLE_CYCLES(20)) uhtwc_host_inst (.clk_in, .reset_in, .bus_io(link.host),
        .cmd_addr_in(ca), .cmd_wdata_in(cd), .cmd_wr_in(cw), .cmd_rd_in(cr), .cmd_rdata_out(crd));
    uhtwc_monitor #(.IDLE_CYCLES(20)) uhtwc_monitor_inst (.clk_in, .reset_in, .addr(link.addr),
        .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
        .bus_idle(link.bus_idle));
    // ----------------------------------------
    // clock, hang guard and bus tasks
    // ----------------------------------------
    always #12.5 clk_in = ~clk_in;
    // a whole run needs well under this many cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            results();
        end
    end
    // one command strobe; read data lands in the cycle after it
    task automatic op(input logic [7:0] a, input logic [7:0] w, input logic we);
        @(posedge clk_in);
        {ca, cd, cw, cr} <= {a, w, we, !we};
        @(posedge clk_in);
        {cw, cr} <= 2'b00;
        #1 rv = crd;
    endtask
    // write, keep the first status, then wait for busy to drop
    task automatic wrc(input logic [7:0] a, input logic [7:0] w);
        op(a, w, 1'b1);
        op(uhtwc_pkg::H_CTRL, 8'h00, 1'b0);
        st = rv;
        for (int i = 0; i < 40 && rv[0] !== 1'b0; i++) op(uhtwc_pkg::H_CTRL, 8'h00, 1'b0);
    endtask
    task automatic peek(input logic [2:0] i, input logic [7:0] x);
        wrc(uhtwc_pkg::H_PEEK, {5'h0, i});
        op(uhtwc_pkg::H_PEEK, 8'h00, 1'b0);
        `CHK("peek", x, rv)
    endtask
    // forced levels replace the buffer only while forcing is on
    task automatic pins(input logic [7:0] b);
        logic [2:0] x;
        @(posedge clk_in);
        #1 x = {b[1] ? b[3:2] : txb[1:0], b[0] | txb[2]};
        `CHK("pins", x, {dm, dp, oe})
    endtask
    // one event cycle, answers in the next, then count cycles to overflow
    task automatic pulse(input logic [18:0] x);
        @(posedge clk_in);
        ev <= x;
        @(posedge clk_in);
        ev <= '0;
        #1 an = {ack, nak};
        for (n = 1; n < 140 && irq !== 1'b1; n++) @(posedge clk_in) #1;
    endtask
    task automatic results();
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        txb <= 3'($random(seed));
        peek(3'h0, uhtwc_pkg::TSR_RST);
        peek(3'h1, uhtwc_pkg::BLF_RST);
        peek(3'h7, 8'h00);
        wrc(uhtwc_pkg::H_CTRL, 8'h01);
        `CHK("no idle", 1'b1, st[1])
        wrc(uhtwc_pkg::H_RESV, 8'h03);
        `CHK("two resv", 1'b1, st[1])
        wrc(uhtwc_pkg::H_RESV, 8'h30);
        `CHK("stall nak", 1'b1, st[1])
        wrc(uhtwc_pkg::H_RESV, 8'h60);
        `CHK("ack nak", 1'b1, st[1])
        @(posedge clk_in);
        idle <= 1'b1;
        repeat (30) @(posedge clk_in);
        pins(uhtwc_pkg::BLF_RST);
        wrc(uhtwc_pkg::H_CTRL, 8'h01);
        pins(uhtwc_pkg::BLF_RESUME_K);
        wrc(uhtwc_pkg::H_CTRL, 8'h02);
        pins(uhtwc_pkg::BLF_RST);
        for (k = 0; k < 15; k++) begin
            r = $random(seed);
            s = $random(seed) & $random(seed) & $random(seed);
            tsr = {6'h0, r[1:0]};
            rsv = r[2] ? 8'h40 : 8'h28;
            wrc(uhtwc_pkg::H_TSR, tsr);
            wrc(uhtwc_pkg::H_RESV, rsv);
            peek(3'h2, rsv);
            peek(3'h3, {7'h00, rsv[5]});
            v = 19'((r & 32'h107e) | (s & 32'he380) | (32'h1 << kb[k % 3]));
            tok = v[4] && v[9:7] == 3'h0;
            dok = v[12] && v[15:13] == 3'h0;
            e = (v[11] && tsr[1] && dok) || (v[0] && tsr[0] && tok && v[5]
                && (v[2] || v[3])) ? 65 : 140;
            pulse(v);
            `CHK("ack", rsv[6] && v[10] && dok, an[1])
            `CHK("nak", rsv[3] && v[0] && v[1] && v[6] && tok, an[0])
            `CHK("fast", e, n)
            peek(3'h0, (v[0] && v[3] && v[5] && tok) ? 8'h01 : tsr);
        end
        wrc(uhtwc_pkg::H_MODE, 8'h01);
        peek(3'h5, 8'h01);
        @(posedge clk_in);
        tick <= 1'b1;
        for (k = 16; k < 19; k++) begin
            pulse(19'h1 << k);
            `CHK("slow", 129, n)
            @(posedge clk_in) #1 `CHK("stop", 1'b1, stp)
            peek(3'h4, 8'h80);
            wrc(uhtwc_pkg::H_PRS, 8'h00);
            peek(3'h4, 8'h00);
        end
        results();
    end
endmodule
